// ### core/cell_monitor_node.sv
// Cell monitor node: link decode, conversions, pump gates and power modes
// Overview of operation
// RULE_01: Voltage conversions start only on master command
// RULE_02: Temperature from internal or external diode sensors
// RULE_03: Temperature reuses converters, scheduled by master
// RULE_04: Latest result per cell read on request
// RULE_05: Lower cell gates pump south and north
// RULE_06: Upper cell gates pump south and north
// RULE_07: Master never drives missing-neighbour end gates
// RULE_08: Gate charges inductor, then releases it
// RULE_09: Master decides balancing; node only switches
// RULE_10: Both directions, every battery state
// RULE_11: Serial input regenerated onto serial output
// RULE_12: Standby default, protection keeps running
// RULE_13: Link event wakes; stay active while busy
// RULE_14: Automatic return to standby when idle
// RULE_15: Undervoltage mode needs command and low cells
// RULE_16: Master sets pump frequency and duty
// RULE_17: South gates use complementary duty cycle
// RULE_18: Timeout drops gates, abandons work
// RULE_19: Defined command set for all operations
`include "cell_monitor_defs.svh"
module cell_monitor_node
  import cell_monitor_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `LINK_TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  cell_link_if.node link,
  output logic convStart,
  output logic convTemp,
  output logic [1:0] convSensor,
  input wire logic convDone,
  input wire logic [`WORD_W-1:0] convLo,
  input wire logic [`WORD_W-1:0] convHi,
  input wire logic uvBelow,
  output logic cellLoSouthGate,
  output logic cellLoNorthGate,
  output logic cellHiSouthGate,
  output logic cellHiNorthGate,
  output logic modeActive,
  output logic modeUnderv
);
  mode_type mode_r;
  logic rxBusy_r;
  logic [`BIT_CNT_W-1:0] rxCnt_r;
  logic [`WORD_W-1:0] rxShift_r;
  logic rxDone;
  logic [`WORD_W-1:0] rxWord;
  opcode_type op;
  logic linkEvent;
  logic fwd_r;
  logic txBusy_r;
  logic [`BIT_CNT_W-1:0] txCnt_r;
  logic [`WORD_W:0] txShift_r;
  logic up_r;
  logic convBusy_r;
  logic start_r;
  logic temp_r;
  logic [1:0] sensor_r;
  logic [`WORD_W-1:0] voltLo_r;
  logic [`WORD_W-1:0] voltHi_r;
  logic [`WORD_W-1:0] tempLo_r;
  logic [`WORD_W-1:0] tempHi_r;
  logic [`WORD_W-1:0] readSel;
  logic [3:0] pumpEn_r;
  logic [`PWM_W-1:0] period_r;
  logic [`PWM_W-1:0] duty_r;
  logic [`PWM_W-1:0] pwmCnt_r;
  logic northPhase;
  logic [3:0] gate_r;
  logic [$clog2(TIMEOUT_CYCLES+1)-1:0] idleCnt_r;
  logic timeout;
  logic nodeIdle;

  assign linkEvent = !rxBusy_r && !link.lanDown;
  assign rxWord = {link.lanDown, rxShift_r[`WORD_W-1:1]};
  assign rxDone = rxBusy_r && rxCnt_r == `LAST_DATA_BIT;
  assign op = opcode_type'(rxWord[`OP_MSB:`OP_LSB]);
  assign timeout = idleCnt_r == ($clog2(TIMEOUT_CYCLES+1))'(TIMEOUT_CYCLES);

  // Received bit regenerated one cycle later, full swing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwd_r <= 1'b1;
    end else begin
      fwd_r <= link.lanDown; // RULE_11
    end
  end
  assign link.lanFwd = fwd_r;

  // Start bit low, then data bits LSB first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxBusy_r <= 1'b0;
      rxCnt_r <= '0;
      rxShift_r <= '0;
    end else if (!rxBusy_r) begin
      rxBusy_r <= !link.lanDown;
      rxCnt_r <= `BIT_CNT_W'(1);
    end else begin
      rxShift_r <= rxWord;
      rxCnt_r <= rxCnt_r + 1'b1;
      if (rxDone) begin
        rxBusy_r <= 1'b0;
      end
    end
  end

  // Both cells converted together on one start pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      convBusy_r <= 1'b0;
      start_r <= 1'b0;
      temp_r <= 1'b0;
      sensor_r <= `SENS_INTERNAL;
    end else begin
      start_r <= 1'b0;
      if (timeout) begin
        convBusy_r <= 1'b0; // RULE_18
      end else if (convBusy_r) begin
        convBusy_r <= !convDone;
      end else if (rxDone && op == OP_MEAS_V) begin
        convBusy_r <= 1'b1; // RULE_01
        start_r <= 1'b1;
        temp_r <= 1'b0;
      end else if (rxDone && op == OP_MEAS_T && rxWord[1:0] != `SENS_NONE) begin
        // Same converters, own command, so independent of voltage reads
        convBusy_r <= 1'b1; // RULE_03
        start_r <= 1'b1;
        temp_r <= 1'b1;
        sensor_r <= rxWord[1:0]; // RULE_02
      end
    end
  end
  assign convStart = start_r;
  assign convTemp = temp_r;
  assign convSensor = sensor_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      voltLo_r <= '0;
      voltHi_r <= '0;
      tempLo_r <= '0;
      tempHi_r <= '0;
    end else if (convBusy_r && convDone && !timeout) begin
      if (temp_r) begin
        tempLo_r <= convLo;
        tempHi_r <= convHi;
      end else begin
        voltLo_r <= convLo; // RULE_04
        voltHi_r <= convHi;
      end
    end
  end

  always_comb begin
    unique case (rxWord[1:0])
      `SEL_VOLT_LO: readSel = voltLo_r;
      `SEL_VOLT_HI: readSel = voltHi_r;
      `SEL_TEMP_LO: readSel = tempLo_r;
      `SEL_TEMP_HI: readSel = tempHi_r;
    endcase
  end

  // Reply frame: start bit then data; a read during a reply is dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txBusy_r <= 1'b0;
      txCnt_r <= '0;
      txShift_r <= '1;
      up_r <= 1'b1;
    end else if (txBusy_r) begin
      up_r <= txShift_r[0];
      txShift_r <= {1'b1, txShift_r[`WORD_W:1]};
      txCnt_r <= txCnt_r + 1'b1;
      txBusy_r <= txCnt_r != `LAST_FRAME_BIT;
    end else if (rxDone && op == OP_READ) begin
      txBusy_r <= 1'b1; // RULE_04
      txShift_r <= {readSel, 1'b0};
      txCnt_r <= '0;
    end
  end
  assign link.lanUp = up_r;

  // Gate enables set by commands only; timeout and undervoltage entry also clear them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pumpEn_r <= '0;
      period_r <= `PUMP_PERIOD_RST;
      duty_r <= `PUMP_DUTY_RST;
    end else if (timeout || (rxDone && op == OP_UNDERV && uvBelow)) begin
      pumpEn_r <= '0; // RULE_18
    end else if (rxDone) begin
      unique case (op)
        OP_PUMP_EN: pumpEn_r <= rxWord[3:0]; // RULE_09
        OP_PUMP_PER: period_r <= rxWord[`PWM_W-1:0]; // RULE_16
        OP_PUMP_DUTY: duty_r <= rxWord[`PWM_W-1:0]; // RULE_16
        default: ;
      endcase
    end
  end

  // No gating by battery current direction: pumps run charging or not
  always_ff @(posedge sys_clk) begin
    if (rst || period_r == '0) begin
      pwmCnt_r <= '0;
    end else begin
      pwmCnt_r <= (pwmCnt_r >= period_r - 1'b1) ? '0 : pwmCnt_r + 1'b1; // RULE_10
    end
  end
  assign northPhase = pwmCnt_r < duty_r;

  // On phase charges the inductor, off phase lets it dump through the body diode
  always_ff @(posedge sys_clk) begin
    if (rst || period_r == '0) begin
      gate_r <= '0;
    end else begin
      gate_r[`GATE_LO_S] <= pumpEn_r[`GATE_LO_S] && !northPhase; // RULE_05 RULE_17 RULE_08
      gate_r[`GATE_LO_N] <= pumpEn_r[`GATE_LO_N] && northPhase; // RULE_05 RULE_08
      gate_r[`GATE_HI_S] <= pumpEn_r[`GATE_HI_S] && !northPhase; // RULE_06 RULE_17
      gate_r[`GATE_HI_N] <= pumpEn_r[`GATE_HI_N] && northPhase; // RULE_06
    end
  end
  assign cellLoSouthGate = gate_r[`GATE_LO_S];
  assign cellLoNorthGate = gate_r[`GATE_LO_N];
  assign cellHiSouthGate = gate_r[`GATE_HI_S];
  assign cellHiNorthGate = gate_r[`GATE_HI_N];

  // Timeout counter runs in every mode, standby included
  always_ff @(posedge sys_clk) begin
    if (rst || linkEvent || timeout) begin
      idleCnt_r <= '0; // RULE_12
    end else begin
      idleCnt_r <= idleCnt_r + 1'b1;
    end
  end

  assign nodeIdle = !rxBusy_r && !convBusy_r && !txBusy_r && pumpEn_r == '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= MODE_STANDBY; // RULE_12
    end else begin
      unique case (mode_r)
        MODE_STANDBY: begin
          if (linkEvent) begin
            mode_r <= MODE_ACTIVE; // RULE_13
          end
        end
        MODE_ACTIVE: begin
          // Start bit at expiry keeps the node awake for its frame
          if (timeout && !linkEvent) begin
            mode_r <= MODE_STANDBY; // RULE_18
          end else if (rxDone && op == OP_UNDERV && uvBelow) begin
            mode_r <= MODE_UNDERV; // RULE_15
          end else if (nodeIdle && !linkEvent && !rxDone) begin
            mode_r <= MODE_STANDBY; // RULE_14
          end
        end
        MODE_UNDERV: begin
          if (linkEvent) begin
            mode_r <= MODE_ACTIVE; // RULE_13
          end
        end
        default: mode_r <= MODE_STANDBY;
      endcase
    end
  end
  assign modeActive = mode_r == MODE_ACTIVE;
  assign modeUnderv = mode_r == MODE_UNDERV;
endmodule

// ### core/cell_monitor_defs.svh
// Constants shared by both ends of the cell monitor link
`ifndef CELL_MONITOR_DEFS_SVH
`define CELL_MONITOR_DEFS_SVH
`define CLK_MHZ 125
`define LINK_TIMEOUT_US 1000
`define LINK_TIMEOUT_CYCLES (`LINK_TIMEOUT_US * `CLK_MHZ)
`define WORD_W 16
`define BIT_CNT_W 5
`define LAST_DATA_BIT 5'h10
`define LAST_FRAME_BIT 5'h11
`define OP_MSB 15
`define OP_LSB 12
`define CMD_NOP 4'h0
`define CMD_MEAS_V 4'h1
`define CMD_MEAS_T 4'h2
`define CMD_READ 4'h3
`define CMD_PUMP_EN 4'h4
`define CMD_PUMP_PER 4'h5
`define CMD_PUMP_DUTY 4'h6
`define CMD_UNDERV 4'h7
`define SENS_INTERNAL 2'h0
`define SENS_EXT1 2'h1
`define SENS_EXT2 2'h2
`define SENS_NONE 2'h3
`define SEL_VOLT_LO 2'h0
`define SEL_VOLT_HI 2'h1
`define SEL_TEMP_LO 2'h2
`define SEL_TEMP_HI 2'h3
`define PWM_W 10
`define PUMP_PERIOD_RST 10'h262
`define PUMP_DUTY_RST 10'h0C9
`define GATE_LO_S 0
`define GATE_LO_N 1
`define GATE_HI_S 2
`define GATE_HI_N 3
`endif

// ### core/cell_monitor_pkg.sv
// Types shared by both ends of the cell monitor link
`include "cell_monitor_defs.svh"
package cell_monitor_pkg;
  typedef enum logic [3:0] {
    OP_NOP = `CMD_NOP,
    OP_MEAS_V = `CMD_MEAS_V,
    OP_MEAS_T = `CMD_MEAS_T,
    OP_READ = `CMD_READ,
    OP_PUMP_EN = `CMD_PUMP_EN,
    OP_PUMP_PER = `CMD_PUMP_PER,
    OP_PUMP_DUTY = `CMD_PUMP_DUTY,
    OP_UNDERV = `CMD_UNDERV
  } opcode_type;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_ACTIVE = 2'h1,
    MODE_UNDERV = 2'h2
  } mode_type;
endpackage

// ### core/cell_link_if.sv
// One-wire command link down the chain and reply wire up
interface cell_link_if;
  logic lanDown;
  logic lanUp;
  logic lanFwd;
  modport master (output lanDown, input lanUp);
  modport node (input lanDown, output lanUp, output lanFwd);
endinterface

// ### core/word_fifo.sv
// Parameterised word FIFO with valid and ready on both sides
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign inReady = count_r != (AW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### core/cell_monitor_master.sv
// Master end: command queue, periodic scans, link serialiser and reply capture
`include "cell_monitor_defs.svh"
module cell_monitor_master
  import cell_monitor_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int SCAN_CYCLES = 1000,
  parameter int TEMP_EVERY = 4,
  parameter bit NODE_IS_LOWEST = 1'b1,
  parameter bit NODE_IS_HIGHEST = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  cell_link_if.master link,
  input wire logic scanEnable,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [`WORD_W-1:0] cmdWord,
  output logic rspValid,
  output logic [`WORD_W-1:0] rspWord
);
  logic [$clog2(SCAN_CYCLES+1)-1:0] scanCnt_r;
  logic [$clog2(TEMP_EVERY+1)-1:0] tempCnt_r;
  logic [1:0] sensor_r;
  logic scanPend_r;
  logic [`WORD_W-1:0] scanWord_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic [`WORD_W-1:0] fifoOut;
  logic [`WORD_W-1:0] sendWord;
  logic txBusy_r;
  logic [`BIT_CNT_W-1:0] txCnt_r;
  logic [`WORD_W+1:0] txShift_r;
  logic down_r;
  logic rxBusy_r;
  logic [`BIT_CNT_W-1:0] rxCnt_r;
  logic [`WORD_W-1:0] rxShift_r;
  logic [`WORD_W-1:0] rxWord;
  logic rspValid_r;
  logic [`WORD_W-1:0] rspWord_r;

  // Voltage scans on a timer, temperature every few scans instead
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scanCnt_r <= '0;
      tempCnt_r <= '0;
      sensor_r <= `SENS_INTERNAL;
      scanPend_r <= 1'b0;
      scanWord_r <= '0;
    end else if (scanPend_r) begin
      scanPend_r <= !fifoInReady;
    end else if (scanEnable && scanCnt_r == ($clog2(SCAN_CYCLES+1))'(SCAN_CYCLES - 1)) begin
      scanCnt_r <= '0;
      scanPend_r <= 1'b1;
      if (tempCnt_r == ($clog2(TEMP_EVERY+1))'(TEMP_EVERY - 1)) begin
        tempCnt_r <= '0;
        scanWord_r <= {`CMD_MEAS_T, 10'h000, sensor_r}; // RULE_03
        sensor_r <= (sensor_r == `SENS_EXT2) ? `SENS_INTERNAL : sensor_r + 1'b1;
      end else begin
        tempCnt_r <= tempCnt_r + 1'b1;
        scanWord_r <= {`CMD_MEAS_V, 12'h000}; // RULE_01
      end
    end else if (scanEnable) begin
      scanCnt_r <= scanCnt_r + 1'b1;
    end
  end

  // Scan words take the queue first; user commands wait
  assign cmdReady = fifoInReady && !scanPend_r; // RULE_09

  word_fifo #(.WIDTH(`WORD_W), .DEPTH(DEPTH)) cmdQueue (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(scanPend_r || cmdValid),
    .inReady(fifoInReady),
    .inData(scanPend_r ? scanWord_r : cmdWord),
    .outValid(fifoOutValid),
    .outReady(!txBusy_r),
    .outData(fifoOut)
  );

  // End-of-string gates have no neighbour and are stripped here
  always_comb begin
    sendWord = fifoOut;
    if (fifoOut[`OP_MSB:`OP_LSB] == `CMD_PUMP_EN) begin
      if (NODE_IS_LOWEST) begin
        sendWord[`GATE_LO_S] = 1'b0; // RULE_07
      end
      if (NODE_IS_HIGHEST) begin
        sendWord[`GATE_HI_N] = 1'b0; // RULE_07
      end
    end
  end

  // Start bit, data LSB first, one stop bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txBusy_r <= 1'b0;
      txCnt_r <= '0;
      txShift_r <= '1;
      down_r <= 1'b1;
    end else if (txBusy_r) begin
      down_r <= txShift_r[0];
      txShift_r <= {1'b1, txShift_r[`WORD_W+1:1]};
      txCnt_r <= txCnt_r + 1'b1;
      txBusy_r <= txCnt_r != `LAST_FRAME_BIT;
    end else if (fifoOutValid) begin
      txBusy_r <= 1'b1; // RULE_16 RULE_15 RULE_19
      txShift_r <= {1'b1, sendWord, 1'b0};
      txCnt_r <= '0;
    end
  end
  assign link.lanDown = down_r;

  assign rxWord = {link.lanUp, rxShift_r[`WORD_W-1:1]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxBusy_r <= 1'b0;
      rxCnt_r <= '0;
      rxShift_r <= '0;
      rspValid_r <= 1'b0;
      rspWord_r <= '0;
    end else begin
      rspValid_r <= 1'b0;
      if (!rxBusy_r) begin
        rxBusy_r <= !link.lanUp;
        rxCnt_r <= `BIT_CNT_W'(1);
      end else begin
        rxShift_r <= rxWord;
        rxCnt_r <= rxCnt_r + 1'b1;
        if (rxCnt_r == `LAST_DATA_BIT) begin
          rxBusy_r <= 1'b0;
          rspValid_r <= 1'b1;
          rspWord_r <= rxWord;
        end
      end
    end
  end
  assign rspValid = rspValid_r;
  assign rspWord = rspWord_r;
endmodule

// ### bench/cell_monitor_node_control_assertions.sv
// Checker on the link wires and node outputs
module cell_monitor_node_control_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lanDown,
  input wire logic lanUp,
  input wire logic lanFwd,
  input wire logic convStart,
  input wire logic cellLoSouthGate,
  input wire logic cellLoNorthGate,
  input wire logic cellHiSouthGate,
  input wire logic cellHiNorthGate,
  input wire logic modeActive,
  input wire logic modeUnderv
);
  logic [4:0] downCnt_r;
  logic [4:0] upCnt_r;
  logic [3:0] gates;
  assign gates = {cellHiNorthGate, cellHiSouthGate, cellLoNorthGate, cellLoSouthGate};
  // Bit position within a frame, 0 while idle
  always_ff @(posedge sys_clk) begin
    if (rst || downCnt_r == 5'h11) begin
      downCnt_r <= 5'h00;
    end else if (downCnt_r != 5'h00 || !lanDown) begin
      downCnt_r <= downCnt_r + 5'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || upCnt_r == 5'h11) begin
      upCnt_r <= 5'h00;
    end else if (upCnt_r != 5'h00 || !lanUp) begin
      upCnt_r <= upCnt_r + 5'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence frameStart;
    downCnt_r == 5'h00 && !lanDown;
  endsequence
  // Three cycles so a gate register one cycle late is not flagged
  sequence standbyHeld;
    (!modeActive && !modeUnderv) [*3];
  endsequence
  AST_FWD_COPY: assert property (lanFwd == $past(lanDown))
    else $error("forwarded bit differs from input");
  AST_DOWN_STOP: assert property (downCnt_r == 5'h11 |-> lanDown)
    else $error("command frame lacks stop bit");
  AST_UP_STOP: assert property (upCnt_r == 5'h11 |-> lanUp)
    else $error("reply frame not idle after data");
  AST_WAKE: assert property (frameStart |-> ##[1:4] modeActive)
    else $error("start bit did not wake node");
  AST_CONV_PULSE: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  AST_CONV_CMD: assert property (convStart |-> downCnt_r == 5'h11 || downCnt_r == 5'h00)
    else $error("conversion started without a command");
  AST_GATE_EXCL: assert property (!(gates[0] && gates[1]) && !(gates[2] && gates[3]))
    else $error("north and south gate of one cell both on");
  AST_END_GATES: assert property (!cellLoSouthGate && !cellHiNorthGate)
    else $error("end gate of string driven");
  AST_UNDERV_OFF: assert property (modeUnderv && $past(modeUnderv) |-> gates == 4'h0)
    else $error("gate on in undervoltage mode");
  AST_STANDBY_OFF: assert property (standbyHeld |-> gates == 4'h0)
    else $error("gate on in standby");
endmodule

// ### bench/cell_monitor_node_control_tb_top.sv
// Bench joining master and node ends over the link
module cell_monitor_node_control_tb_top
  import cell_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scanEnable = 1'b0;
  logic cmdValid = 1'b0;
  logic [15:0] cmdWord = 16'h0000;
  logic convDone = 1'b0;
  logic [15:0] convLo = 16'h0000;
  logic [15:0] convHi = 16'h0000;
  logic uvBelow = 1'b0;
  logic cmdReady, rspValid, convStart, convTemp, modeActive, modeUnderv;
  logic cellLoSouthGate, cellLoNorthGate, cellHiSouthGate, cellHiNorthGate;
  logic [15:0] rspWord;
  logic [1:0] convSensor;
  int fails = 0;
  int check_count = 0;
  int n;
  int cnt [5];
  cell_link_if cell_link_if_i ();
  cell_monitor_master #(.DEPTH(16), .SCAN_CYCLES(50)) cell_monitor_master_i (
    .sys_clk(sys_clk), .rst(rst), .link(cell_link_if_i), .scanEnable(scanEnable), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWord(cmdWord), .rspValid(rspValid), .rspWord(rspWord));
  // Short timeout keeps the run brief
  cell_monitor_node #(.TIMEOUT_CYCLES(200)) cell_monitor_node_i (
    .sys_clk(sys_clk), .rst(rst), .link(cell_link_if_i), .convStart(convStart), .convTemp(convTemp),
    .convSensor(convSensor), .convDone(convDone), .convLo(convLo), .convHi(convHi), .uvBelow(uvBelow),
    .cellLoSouthGate(cellLoSouthGate), .cellLoNorthGate(cellLoNorthGate), .cellHiSouthGate(cellHiSouthGate),
    .cellHiNorthGate(cellHiNorthGate), .modeActive(modeActive), .modeUnderv(modeUnderv));
  cell_monitor_node_control_assertions cell_monitor_node_control_assertions_i (
    .sys_clk(sys_clk), .rst(rst), .lanDown(cell_link_if_i.lanDown), .lanUp(cell_link_if_i.lanUp),
    .lanFwd(cell_link_if_i.lanFwd), .convStart(convStart), .cellLoSouthGate(cellLoSouthGate),
    .cellLoNorthGate(cellLoNorthGate), .cellHiSouthGate(cellHiSouthGate), .cellHiNorthGate(cellHiNorthGate),
    .modeActive(modeActive), .modeUnderv(modeUnderv));
  always #4 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic give_up();
    fails++;
    print_verdict();
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Returns once the queue has taken the word
  task automatic send(input logic [15:0] w);
    int i;
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdWord <= w;
    for (i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (cmdReady === 1'b1) break;
    end
    if (i == 400) give_up();
    @(posedge sys_clk);
    cmdValid <= 1'b0;
  endtask
  task automatic answer(input logic t, input logic [1:0] s, input logic [15:0] lo, input logic [15:0] hi);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      if (convStart === 1'b1) break;
    end
    if (i == 60) give_up();
    check(modeActive, 1'b1);
    @(posedge sys_clk);
    convDone <= 1'b1;
    convLo <= lo;
    convHi <= hi;
    @(posedge sys_clk);
    convDone <= 1'b0;
    convLo <= ~lo;
    convHi <= ~hi;
    check(convTemp, t);
    if (t) check(convSensor, s);
  endtask
  task automatic read_result(input logic [1:0] sel, input logic [15:0] exp);
    int i;
    send({OP_READ, 10'h000, sel});
    for (i = 0; i < 80; i++) begin
      @(negedge sys_clk);
      if (rspValid === 1'b1) break;
    end
    if (i == 80) give_up();
    check(rspWord, exp);
  endtask
  task automatic wait_active(input logic want, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(negedge sys_clk);
      if (modeActive === want) break;
    end
    check(modeActive, want);
  endtask
  task automatic sample(input int cycles);
    cnt = '{default: 0};
    repeat (cycles) begin
      @(negedge sys_clk);
      cnt[0] += int'(cellLoSouthGate === 1'b1);
      cnt[1] += int'(cellLoNorthGate === 1'b1);
      cnt[2] += int'(cellHiSouthGate === 1'b1);
      cnt[3] += int'(cellHiNorthGate === 1'b1);
      cnt[4] += int'(convStart === 1'b1);
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    sample(2);
    check({modeUnderv, modeActive}, 16'h0000);
    check(16'(cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4]), 16'h0000);
    send({OP_MEAS_V, 12'h000});
    answer(1'b0, 2'h0, 16'h0ABC, 16'h0DEF);
    read_result(2'h0, 16'h0ABC);
    read_result(2'h1, 16'h0DEF);
    for (int s = 0; s < 3; s++) begin
      send({OP_MEAS_T, 10'h000, s[1:0]});
      answer(1'b1, s[1:0], 16'h0100 + 16'(s), 16'h0200 + 16'(s));
    end
    read_result(2'h2, 16'h0102);
    read_result(2'h3, 16'h0202);
    read_result(2'h0, 16'h0ABC);
    send({OP_MEAS_T, 12'h003});
    sample(40);
    check(16'(cnt[4]), 16'h0000);
    wait_active(1'b0, 100);
    send({OP_PUMP_PER, 12'h00A});
    send({OP_PUMP_DUTY, 12'h003});
    send({OP_PUMP_EN, 12'h00F});
    // Enable lands about 55 cycles after its push, behind two queued frames
    sample(60);
    // Whole periods only, so the count does not depend on phase
    sample(100);
    check(16'(cnt[1]), 16'h001E);
    check(16'(cnt[2]), 16'h0046);
    check(16'(cnt[0] + cnt[3]), 16'h0000);
    check(modeActive, 1'b1);
    wait_active(1'b0, 300);
    sample(10);
    check(16'(cnt[1] + cnt[2]), 16'h0000);
    send({OP_UNDERV, 12'h000});
    sample(25);
    check(modeUnderv, 1'b0);
    @(posedge sys_clk);
    uvBelow <= 1'b1;
    send({OP_UNDERV, 12'h000});
    sample(25);
    check(modeUnderv, 1'b1);
    send({OP_NOP, 12'h000});
    wait_active(1'b1, 30);
    @(posedge sys_clk);
    uvBelow <= 1'b0;
    cmdValid <= 1'b1;
    cmdWord <= {OP_NOP, 12'h000};
    n = 0;
    repeat (30) begin
      @(negedge sys_clk);
      n += int'(cmdReady === 1'b0);
    end
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    check(16'(n > 0), 16'h0001);
    for (n = 0; n < 600 && cmdReady !== 1'b1; n++) @(negedge sys_clk);
    check(cmdReady, 1'b1);
    @(posedge sys_clk);
    scanEnable <= 1'b1;
    sample(500);
    check(16'(cnt[4] > 0), 16'h0001);
    print_verdict();
  end
endmodule
